// ==== exb_map.svh ====
// Constants for the expansion bus wait-state controller
`ifndef EXB_MAP_SVH
`define EXB_MAP_SVH

// ****************************************
// Widths
// ****************************************
`define EXB_NUM_CS         6
`define EXB_CS_IDX_W       3
`define EXB_WAIT_W         4
`define EXB_ADDR_W         26
`define EXB_DATA_W         32
`define EXB_PH_W           2

// ****************************************
// Timing
// ****************************************
`define EXB_SYS_PERIOD_NS  10
`define EXB_BUS_PERIOD_NS  27
`define EXB_BUS_CYC        ((`EXB_BUS_PERIOD_NS + `EXB_SYS_PERIOD_NS - 1) / `EXB_SYS_PERIOD_NS)
`define EXB_PH_LAST        2'((`EXB_BUS_CYC) - 1)
`define EXB_PH_FALL        2'((`EXB_BUS_CYC) - 2)
`define EXB_PH_FIRST       2'h0

// ****************************************
// Values
// ****************************************
`define EXB_FAST_MIN_WAIT  4'h1
`define EXB_WAIT_ZERO      4'h0
`define EXB_WAIT_ONE       4'h1
`define EXB_CS_IDLE        6'h3f
`define EXB_CS_ONE         6'h01
`define EXB_DATA_ZERO      32'h0000_0000
`define EXB_ADDR_ZERO      26'h000_0000

`endif

// ==== exb_pkg.sv ====
// Types shared by the expansion bus wait-state controller
`include "exb_map.svh"
package exb_pkg;

    // ****************************************
    // Access request from the core side
    // ****************************************
    typedef struct packed {
        logic [`EXB_CS_IDX_W-1:0] cs_idx;
        logic                     write;
        logic                     burst;
        logic [`EXB_ADDR_W-1:0]   addr;
        logic [`EXB_DATA_W-1:0]   wdata;
    } exb_req_s;

    // ****************************************
    // Static configuration inputs
    // ****************************************
    typedef struct packed {
        logic [`EXB_NUM_CS-1:0][`EXB_WAIT_W-1:0] cs_wait;
        logic [`EXB_WAIT_W-1:0]                  seq_wait;
        logic                                    sequential_access_enable;
        logic                                    fast_bus_mode;
    } exb_cfg_s;

    typedef enum logic [2:0] {
        EXB_IDLE,
        EXB_ADDR,
        EXB_WAIT,
        EXB_XFER,
        EXB_HOLD,
        EXB_GAP
    } exb_state_e;

endpackage

// ==== exb_sync.sv ====
// Two-flop synchroniser for pins from outside the clock domain
module exb_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             sys_rst,
    // Data
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    // The first stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;
endmodule

// ==== exb_wait_ctrl.sv ====
// Expansion bus cycle controller with programmed and ready-driven wait states
`include "exb_map.svh"
module exb_wait_ctrl (
    // Clock and reset
    input  wire logic                     clk,
    input  wire logic                     sys_rst,
    // Core request
    input  wire logic                     req_valid,
    output logic                          req_ready,
    input  wire exb_pkg::exb_req_s        req,
    // Core response
    output logic                          resp_valid,
    output logic [`EXB_DATA_W-1:0]        resp_rdata,
    // Configuration
    input  wire exb_pkg::exb_cfg_s        cfg,
    // Expansion pins
    output logic                          expansion_clock_out,
    output logic [`EXB_NUM_CS-1:0]        expansion_chip_select_n,
    output logic                          memory_output_enable_n,
    output logic                          memory_write_strobe_n,
    output logic [`EXB_ADDR_W-1:0]        exp_addr,
    output logic [`EXB_DATA_W-1:0]        exp_data_out,
    output logic                          exp_data_oe,
    input  wire logic [`EXB_DATA_W-1:0]   exp_data_in,
    input  wire logic                     expansion_ready_in
);
    import exb_pkg::*;

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [`EXB_NUM_CS-1:0] cs_decode(input logic [`EXB_CS_IDX_W-1:0] idx);
        cs_decode = ~(`EXB_CS_ONE << idx);
    endfunction

    // At the fast bus clock a zero cs_wait count still costs one wait
    function automatic logic [`EXB_WAIT_W-1:0] eff_wait(input logic [`EXB_WAIT_W-1:0] w,
                                                        input logic fast);
        eff_wait = (fast && w == `EXB_WAIT_ZERO) ? `EXB_FAST_MIN_WAIT : w;
    endfunction

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic                   rdy_sync;
    logic [`EXB_DATA_W-1:0] din_sync;

    // Ready may move at any time relative to the clock output
    exb_sync #(.WIDTH(1)) u_rdy_sync (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .async_in (expansion_ready_in),
        .sync_out (rdy_sync)
    );

    exb_sync #(.WIDTH(`EXB_DATA_W)) u_din_sync (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .async_in (exp_data_in),
        .sync_out (din_sync)
    );

    // ****************************************
    // State
    // ****************************************
    exb_state_e             st_ff,       nxt_st;
    logic [`EXB_PH_W-1:0]   ph_ff,       nxt_ph;
    logic [`EXB_WAIT_W-1:0] wcnt_ff,     nxt_wcnt;
    logic                   rdy_smp_ff,  nxt_rdy_smp;
    logic [`EXB_DATA_W-1:0] dsmp_ff,     nxt_dsmp;
    exb_req_s               cur_ff,      nxt_cur;
    logic [`EXB_NUM_CS-1:0] cs_n_ff,     nxt_cs_n;
    logic                   oe_n_ff,     nxt_oe_n;
    logic                   we_n_ff,     nxt_we_n;
    logic                   doe_ff,      nxt_doe;
    logic                   clk_out_ff,  nxt_clk_out;
    logic                   rvalid_ff,   nxt_rvalid;
    logic [`EXB_DATA_W-1:0] rdata_ff,    nxt_rdata;
    logic                   tick;
    logic                   done;
    logic                   seq_take;

    assign tick     = (ph_ff == `EXB_PH_LAST);
    assign done     = (st_ff == EXB_XFER) && tick && rdy_smp_ff;
    assign seq_take = done && cur_ff.burst && !cur_ff.write && cfg.sequential_access_enable;
    // Requests are only taken on a bus period boundary
    assign req_ready = tick && (st_ff == EXB_IDLE || st_ff == EXB_HOLD || seq_take);

    always_comb begin
        nxt_st      = st_ff;
        nxt_ph      = tick ? `EXB_PH_FIRST : ph_ff + 2'h1;
        nxt_wcnt    = wcnt_ff;
        nxt_rdy_smp = rdy_smp_ff;
        nxt_dsmp    = dsmp_ff;
        nxt_cur     = cur_ff;
        nxt_cs_n    = cs_n_ff;
        nxt_oe_n    = oe_n_ff;
        nxt_we_n    = we_n_ff;
        nxt_doe     = doe_ff;
        nxt_rvalid  = 1'b0;
        nxt_rdata   = rdata_ff;
        // Clock output is low in the last phase so its fall lands before the period end
        nxt_clk_out = (nxt_ph != `EXB_PH_LAST);
        // Ready and read data are caught at the expansion clock falling edge
        if (ph_ff == `EXB_PH_FALL) begin
            nxt_rdy_smp = rdy_sync;
            nxt_dsmp    = din_sync;
        end
        case (st_ff)
            EXB_IDLE, EXB_HOLD: begin
                if (req_valid && tick) begin
                    nxt_st   = EXB_ADDR;
                    nxt_cur  = req;
                    nxt_cs_n = cs_decode(req.cs_idx);
                    nxt_oe_n = req.write;
                    nxt_doe  = req.write;
                end
            end
            EXB_ADDR: begin
                if (tick) begin
                    nxt_wcnt = eff_wait(cfg.cs_wait[cur_ff.cs_idx], cfg.fast_bus_mode);
                    nxt_st   = (nxt_wcnt == `EXB_WAIT_ZERO) ? EXB_XFER : EXB_WAIT;
                    nxt_we_n = !cur_ff.write;
                end
            end
            EXB_WAIT: begin
                if (tick) begin
                    nxt_wcnt = wcnt_ff - `EXB_WAIT_ONE;
                    if (wcnt_ff == `EXB_WAIT_ONE) begin
                        nxt_st = EXB_XFER;
                    end
                end
            end
            EXB_XFER: begin
                // Ready low keeps us here one more period and resamples
                if (done) begin
                    nxt_rvalid = 1'b1;
                    nxt_rdata  = cur_ff.write ? `EXB_DATA_ZERO : dsmp_ff;
                    nxt_we_n   = 1'b1;
                    if (seq_take && req_valid) begin
                        // Next burst word: no idle period, sequential wait count
                        nxt_cur  = req;
                        nxt_wcnt = cfg.seq_wait;
                        nxt_st   = (cfg.seq_wait == `EXB_WAIT_ZERO) ? EXB_XFER : EXB_WAIT;
                    end else if (cur_ff.burst && !cur_ff.write) begin
                        nxt_st = EXB_HOLD;
                    end else begin
                        nxt_cs_n = `EXB_CS_IDLE;
                        nxt_oe_n = 1'b1;
                        nxt_doe  = 1'b0;
                        nxt_st   = cfg.sequential_access_enable ? EXB_IDLE : EXB_GAP;
                    end
                end
            end
            EXB_GAP: begin
                if (tick) begin
                    nxt_st = EXB_IDLE;
                end
            end
            default: nxt_st = EXB_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_ff      <= EXB_IDLE;
            ph_ff      <= `EXB_PH_FIRST;
            wcnt_ff    <= `EXB_WAIT_ZERO;
            rdy_smp_ff <= 1'b0;
            dsmp_ff    <= `EXB_DATA_ZERO;
            cur_ff     <= '0;
            cs_n_ff    <= `EXB_CS_IDLE;
            oe_n_ff    <= 1'b1;
            we_n_ff    <= 1'b1;
            doe_ff     <= 1'b0;
            clk_out_ff <= 1'b1;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= `EXB_DATA_ZERO;
        end else begin
            st_ff      <= nxt_st;
            ph_ff      <= nxt_ph;
            wcnt_ff    <= nxt_wcnt;
            rdy_smp_ff <= nxt_rdy_smp;
            dsmp_ff    <= nxt_dsmp;
            cur_ff     <= nxt_cur;
            cs_n_ff    <= nxt_cs_n;
            oe_n_ff    <= nxt_oe_n;
            we_n_ff    <= nxt_we_n;
            doe_ff     <= nxt_doe;
            clk_out_ff <= nxt_clk_out;
            rvalid_ff  <= nxt_rvalid;
            rdata_ff   <= nxt_rdata;
        end
    end

    assign expansion_clock_out     = clk_out_ff;
    assign expansion_chip_select_n = cs_n_ff;
    assign memory_output_enable_n  = oe_n_ff;
    assign memory_write_strobe_n   = we_n_ff;
    assign exp_addr                = cur_ff.addr;
    assign exp_data_out            = cur_ff.wdata;
    assign exp_data_oe             = doe_ff;
    assign resp_valid              = rvalid_ff;
    assign resp_rdata              = rdata_ff;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_whole_periods: assert property ($changed(st_ff) |-> $past(ph_ff) == `EXB_PH_LAST)
        else $error("state moved off a bus period boundary");
    a_ready_sample: assert property (ph_ff == `EXB_PH_FALL |=> rdy_smp_ff == $past(rdy_sync))
        else $error("ready not sampled at clock fall");
    a_ready_stretch: assert property (st_ff == EXB_XFER && tick && !rdy_smp_ff
                                      |=> st_ff == EXB_XFER ##2 ph_ff == `EXB_PH_LAST)
        else $error("ready low did not stretch the transfer");
    a_seq_wait: assert property (seq_take && req_valid && cfg.seq_wait != `EXB_WAIT_ZERO
                                 |=> st_ff == EXB_WAIT && wcnt_ff == $past(cfg.seq_wait))
        else $error("sequential wait count not used");
    a_no_idle_seq: assert property (done && !cur_ff.burst && cfg.sequential_access_enable
                                    |=> st_ff == EXB_IDLE)
        else $error("idle period inserted in sequential mode");
    a_gap_nonseq: assert property (done && !cur_ff.burst && !cfg.sequential_access_enable
                                   |=> st_ff == EXB_GAP)
        else $error("missing idle period in normal mode");
    a_burst_hold: assert property (st_ff == EXB_HOLD |-> !oe_n_ff && cs_n_ff != `EXB_CS_IDLE)
        else $error("select or output enable released within burst");
    a_cs_single: assert property ($countones(~cs_n_ff) <= 1)
        else $error("more than one chip select active");
    a_fast_min: assert property (st_ff == EXB_ADDR && tick && cfg.fast_bus_mode
                                 |=> st_ff == EXB_WAIT)
        else $error("fast bus access without minimum wait");
    a_wait_end: assert property (st_ff == EXB_WAIT && tick && wcnt_ff == `EXB_WAIT_ONE
                                 |=> st_ff == EXB_XFER)
        else $error("programmed waits not followed by transfer");

    c_write_done: cover property (done && cur_ff.write);
    c_seq_burst:  cover property (seq_take && req_valid);
    c_ready_hold: cover property (st_ff == EXB_XFER && tick && !rdy_smp_ff);
    c_hold_burst: cover property (st_ff == EXB_HOLD ##1 st_ff == EXB_ADDR);
endmodule

// ==== exb_mem_model.sv ====
// Behavioural expansion memory answering the controller's pins
module exb_mem_model (
    // Expansion pins
    input  wire logic [5:0]  cs_n,
    input  wire logic        oe_n,
    input  wire logic        we_n,
    input  wire logic [25:0] addr,
    input  wire logic [31:0] wdata,
    output logic      [31:0] rdata,
    output logic             rdy,
    // Bench control
    input  wire logic [7:0]  hold_ns,
    output logic      [31:0] last_wr
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [31:0] drv = 32'h0;
    initial rdy = 1'b1;
    // Released bus flips on every change so stale data never matches
    always @(oe_n or cs_n or addr) begin
        if (!oe_n && cs_n != 6'h3f) begin
            drv = {6'h15, addr};
        end else begin
            drv = ~drv;
        end
    end
    assign #3 rdata = drv;
    // Ready moves with no relation to the bus clock
    always @(negedge (&cs_n)) begin
        if (hold_ns != 8'h0) begin
            #4 rdy = 1'b0;
            #(hold_ns) rdy = 1'b1;
        end
    end
    always @(posedge we_n) last_wr = wdata;
endmodule

// ==== tb_exb_wait_ctrl.sv ====
// Self-checking bench for the expansion bus wait-state controller
module tb_exb_wait_ctrl;
    timeunit 1ns;
    timeprecision 100ps;
    import exb_pkg::*;
    logic clk, sys_rst, req_valid, req_ready, resp_valid, xclk;
    logic oe_n, we_n, doe, rdy, seen_oe, seen_we, seen_doe;
    exb_req_s req;
    exb_cfg_s cfg;
    logic [31:0] rdata, dout, din, last_wr;
    logic [25:0] addr;
    logic [5:0]  cs_n, seen_cs;
    logic [7:0]  hold_ns;
    int error_cnt = 0;
    int cmp_count = 0;
    time rq_t[$];
    logic [31:0] rq_d[$];
    logic [6:0]  rq_p[$];
    exb_wait_ctrl i_exb_wait_ctrl (.clk(clk), .sys_rst(sys_rst),
        .req_valid(req_valid), .req_ready(req_ready), .req(req),
        .resp_valid(resp_valid), .resp_rdata(rdata), .cfg(cfg),
        .expansion_clock_out(xclk), .expansion_chip_select_n(cs_n),
        .memory_output_enable_n(oe_n), .memory_write_strobe_n(we_n),
        .exp_addr(addr), .exp_data_out(dout), .exp_data_oe(doe),
        .exp_data_in(din), .expansion_ready_in(rdy));
    exb_mem_model i_exb_mem_model (.cs_n(cs_n), .oe_n(oe_n), .we_n(we_n),
        .addr(addr), .wdata(dout), .rdata(din), .rdy(rdy),
        .hold_ns(hold_ns), .last_wr(last_wr));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Pins and responses are looked at mid-cycle, where they are settled
    always @(negedge clk) begin
        if (cs_n != 6'h3f) seen_cs = cs_n;
        if (!oe_n) seen_oe = 1'b1;
        if (!we_n) seen_we = 1'b1;
        if (doe) seen_doe = 1'b1;
        if (resp_valid === 1'b1) begin
            rq_t.push_back($time - 5);
            rq_d.push_back(rdata);
            rq_p.push_back({cs_n, oe_n});
        end
    end
    task automatic check(input string nm, input logic [31:0] got,
                         input logic [31:0] want);
        cmp_count++;
        if (got !== want) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, want, got);
        end
    endtask
    task automatic issue(input logic [2:0] cs, input logic wr, input logic bst,
                         input logic [25:0] a, output time tt);
        int n;
        n = 0;
        @(negedge clk);
        req_valid = 1'b1;
        req = '{cs, wr, bst, a, {6'h0, a} ^ 32'h5a5a_5a5a};
        #1;
        while (req_ready !== 1'b1 && n < 300) begin
            @(negedge clk);
            #1;
            n++;
        end
        if (n == 300) check("ready wait", 32'h0, 32'h1);
        @(posedge clk);
        tt = $time;
        @(negedge clk);
        req_valid = 1'b0;
    endtask
    task automatic result(input string nm, input time t0, input int lat,
                          input logic [31:0] d, input logic [6:0] p);
        for (int n = 0; n < 400 && rq_t.size() == 0; n++) @(posedge clk);
        if (rq_t.size() == 0) begin
            check({nm, " missing"}, 32'h0, 32'h1);
            return;
        end
        check({nm, " latency"}, 32'((rq_t.pop_front() - t0) / 10), 32'(lat));
        check({nm, " data"}, rq_d.pop_front(), d);
        check({nm, " pins"}, 32'(rq_p.pop_front()), 32'(p));
    endtask
    task automatic s_reads();
        time tt;
        for (int i = 0; i < 6; i++) begin
            seen_cs = 6'h3f;
            seen_oe = 1'b0;
            seen_we = 1'b0;
            issue(3'(i), 1'b0, 1'b0, 26'(i * 64 + 5), tt);
            result("read", tt, 6 + 3 * i, {6'h15, 26'(i * 64 + 5)}, 7'h7f);
            check("read select", 32'(seen_cs), 32'(6'h3f ^ (6'h01 << i)));
            check("read strobes", 32'({seen_oe, seen_we}), 32'h2);
        end
    endtask
    task automatic s_write();
        time tt;
        seen_oe = 1'b0;
        seen_we = 1'b0;
        seen_doe = 1'b0;
        issue(3'h3, 1'b1, 1'b0, 26'h012_3456, tt);
        result("write", tt, 15, 32'h0, 7'h7f);
        check("write data", last_wr, 32'h0012_3456 ^ 32'h5a5a_5a5a);
        check("write strobes", 32'({seen_oe, seen_we, seen_doe}), 32'h3);
    endtask
    task automatic s_ready();
        time tt;
        logic [7:0] hl [3] = '{8'h28, 8'h64, 8'h64};
        int cs [3] = '{0, 1, 0};
        int lat [3] = '{9, 15, 15};
        for (int i = 0; i < 3; i++) begin
            hold_ns = hl[i];
            issue(3'(cs[i]), 1'b0, 1'b0, 26'h000_0100, tt);
            result("ready", tt, lat[i], {6'h15, 26'h000_0100}, 7'h7f);
        end
        hold_ns = 8'h0;
    endtask
    task automatic s_fast();
        time tt;
        @(negedge clk);
        cfg.fast_bus_mode = 1'b1;
        issue(3'h0, 1'b0, 1'b0, 26'h000_0200, tt);
        result("fast zero", tt, 9, {6'h15, 26'h000_0200}, 7'h7f);
        issue(3'h2, 1'b0, 1'b0, 26'h000_0204, tt);
        result("fast two", tt, 12, {6'h15, 26'h000_0204}, 7'h7f);
        @(negedge clk);
        cfg.fast_bus_mode = 1'b0;
    endtask
    task automatic s_gap();
        time t0, t1;
        for (int i = 0; i < 2; i++) begin
            @(negedge clk);
            cfg.sequential_access_enable = 1'(i);
            issue(3'h0, 1'b0, 1'b0, 26'h000_0300, t0);
            issue(3'h0, 1'b0, 1'b0, 26'h000_0304, t1);
            check("spacing", 32'((t1 - t0) / 10), 32'(12 - 3 * i));
            result("gap a", t0, 6, {6'h15, 26'h000_0300}, 7'h7f);
            result("gap b", t1, 6, {6'h15, 26'h000_0304}, 7'h7f);
        end
    endtask
    task automatic s_burst();
        time t0, t1;
        for (int i = 0; i < 2; i++) begin
            @(negedge clk);
            cfg.sequential_access_enable = 1'(1 - i);
            issue(3'h5, 1'b0, 1'b1, 26'h000_0400, t0);
            issue(3'h5, 1'b0, 1'b0, 26'h000_0404, t1);
            check("burst spacing", 32'((t1 - t0) / 10), 32'(21 + 3 * i));
            result("burst a", t0, 21, {6'h15, 26'h000_0400}, 7'h3e);
            result("burst b", t1, 9 + 12 * i, {6'h15, 26'h000_0404}, 7'h7f);
        end
    endtask
    // Mid-run reset: pins go idle, then the bus clock restarts high-high-low
    task automatic s_reset();
        @(negedge clk);
        sys_rst = 1'b1;
        repeat (2) @(negedge clk);
        check("reset pins", 32'({cs_n, oe_n, we_n, doe, xclk, resp_valid, req_ready}),
              32'hff4);
        sys_rst = 1'b0;
        for (int k = 0; k < 4; k++) begin
            @(negedge clk);
            check("clock out", 32'({xclk, req_ready}), 32'(k == 1 ? 1 : 2));
        end
    endtask
    task automatic complete_run();
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        sys_rst = 1'b1;
        req_valid = 1'b0;
        req = '0;
        hold_ns = 8'h0;
        cfg = '{24'h54_3210, 4'h2, 1'b0, 1'b0};
        repeat (3) @(posedge clk);
        @(negedge clk);
        sys_rst = 1'b0;
        s_reads();
        s_write();
        s_ready();
        s_fast();
        s_gap();
        s_burst();
        s_reset();
        complete_run();
    end
    // Whole run needs well under a thousand cycles
    initial begin
        #100000;
        error_cnt++;
        complete_run();
    end
endmodule
